/* File: common/ssp_consts.svh */
// constants and the behaviour list for the shared scan/probe pin control
// assumes inclusion by the package, the pin control and the testbench
// Behaviour
// - flexible mode, mode-select low switches clock, data-in, data-out pins to scan duty
// - once in scan duty, pins stay there until the scan machine hits logic reset
// - at logic reset the shared scan pins return to ordinary user I/O
// - controller holds mode-select high; logic reset reached within five test clocks
// - dedicated test mode: mode-select acts as plain standard scan, no sharing
// - any selected internal node can be driven onto the first probe pin
// - second probe works alongside the first, two paths seen at once
// - each probe pin may serve as plain user I/O after verification
// - one-way setting permanently disables both probe outputs; here the lock is cleared again by device reset (nrst_in)
// - serial data enters on data-in, results leave on data-out, timed by test clock
// - test clock also clocks probe selection and programming operations
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_IR_W        4
`define SSP_IR_RESET    4'h1
`define SSP_IR_BYPASS   4'hf
`define SSP_IR_PROBE    4'h2
`define SSP_IR_PROG     4'h3
`define SSP_IR_LOCK     4'h4
`define SSP_IR_CAPTURE  4'h1
`define SSP_RESET_TCKS  5
`define SSP_SEL_W       6
`define SSP_PROG_W      8
`endif

/* File: common/ssp_pkg.sv */
// types for the shared scan/probe pin control
// assumes ssp_consts.svh is on the include path
`include "ssp_consts.svh"
package ssp_pkg;
    typedef enum logic [15:0] {
        SSP_TLR  = 16'h0001, SSP_RTI  = 16'h0002, SSP_SDRS = 16'h0004,
        SSP_CDR  = 16'h0008, SSP_SDR  = 16'h0010, SSP_E1DR = 16'h0020,
        SSP_PDR  = 16'h0040, SSP_E2DR = 16'h0080, SSP_UDR  = 16'h0100,
        SSP_SIRS = 16'h0200, SSP_CIR  = 16'h0400, SSP_SIR  = 16'h0800,
        SSP_E1IR = 16'h1000, SSP_PIR  = 16'h2000, SSP_E2IR = 16'h4000,
        SSP_UIR  = 16'h8000
    } ssp_tap_e;
    // probe routing: selects and enable
    typedef struct packed {
        logic                    enable;
        logic [`SSP_SEL_W-1:0]   sel_second;
        logic [`SSP_SEL_W-1:0]   sel_first;
    } ssp_probe_s;
    // per-pin output pair
    typedef struct packed {
        logic oe;
        logic dout;
    } ssp_pin_s;
endpackage

/* File: src/ssp_sync2.sv */
// two-flop synchroniser, parameterised width
// assumes inputs asynchronous to clk_in
`timescale 1ns/1ns
module ssp_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    // data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) $error("ssp_sync2: width must be positive");
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

/* File: src/ssp_pin_ctrl.sv */
// shared scan/probe pin control: scan state machine on the test clock,
// pin ownership, probe routing, probe lock and user I/O muxing
// assumes test clock is free to stop; node bus and user I/O are on mclk_in
`timescale 1ns/1ns
`include "ssp_consts.svh"
module ssp_pin_ctrl #(
    parameter int NODES = 64
) (
    // system clock and reset
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    // test link, test clock domain
    input  wire logic             tck_in,
    input  wire logic             tms_in,
    input  wire logic             tdi_in,
    output logic                  tdo_out,
    output logic                  tdo_oe_out,
    // mode strap: high selects dedicated test mode
    input  wire logic             dedicated_mode_in,
    // shared pin status, system domain
    output logic                  scan_active_out,
    output logic                  probe_locked_out,
    // internal nodes to observe
    input  wire logic [NODES-1:0] node_in,
    // user side of shared scan pins (clock, data-in, data-out)
    input  wire logic [2:0]       user_dout_in,
    input  wire logic [2:0]       user_oe_in,
    output logic      [2:0]       user_din_out,
    output logic      [2:0]       scan_pin_dout_out,
    output logic      [2:0]       scan_pin_oe_out,
    // probe pins
    input  wire logic [1:0]       probe_user_dout_in,
    input  wire logic [1:0]       probe_user_oe_in,
    output logic                  probe_out_first,
    output logic                  probe_out_second,
    output logic      [1:0]       probe_oe_out,
    // programming word, valid on strobe (test clock domain)
    output logic [`SSP_PROG_W-1:0] prog_word_out,
    output logic                  prog_strobe_out
);
    localparam int SW = `SSP_SEL_W;
    initial begin
        if (NODES < 2 || NODES > (1 << SW)) $error("ssp_pin_ctrl: NODES out of range");
    end

    ssp_pkg::ssp_tap_e           tap_reg;
    ssp_pkg::ssp_tap_e           tap_next;
    logic [`SSP_IR_W-1:0]        ir_sh_reg;
    logic [`SSP_IR_W-1:0]        ir_reg;
    logic [2*SW:0]               dr_reg;
    logic                        byp_reg;
    ssp_pkg::ssp_probe_s         probe_reg;
    logic                        lock_reg;
    logic                        tdo_reg;
    logic                        tdo_en_reg;
    logic                        scan_own_reg;
    logic [`SSP_PROG_W-1:0]      prog_reg;
    logic                        prog_stb_reg;
    logic                        probe_tgl_reg;
    logic [2:0]                  tms_hi_cnt;

    // test-clock state machine; flexible mode only leaves reset on low tms
    always_comb begin
        case (tap_reg)
            ssp_pkg::SSP_TLR:  tap_next = tms_in ? ssp_pkg::SSP_TLR  : ssp_pkg::SSP_RTI;
            ssp_pkg::SSP_RTI:  tap_next = tms_in ? ssp_pkg::SSP_SDRS : ssp_pkg::SSP_RTI;
            ssp_pkg::SSP_SDRS: tap_next = tms_in ? ssp_pkg::SSP_SIRS : ssp_pkg::SSP_CDR;
            ssp_pkg::SSP_CDR:  tap_next = tms_in ? ssp_pkg::SSP_E1DR : ssp_pkg::SSP_SDR;
            ssp_pkg::SSP_SDR:  tap_next = tms_in ? ssp_pkg::SSP_E1DR : ssp_pkg::SSP_SDR;
            ssp_pkg::SSP_E1DR: tap_next = tms_in ? ssp_pkg::SSP_UDR  : ssp_pkg::SSP_PDR;
            ssp_pkg::SSP_PDR:  tap_next = tms_in ? ssp_pkg::SSP_E2DR : ssp_pkg::SSP_PDR;
            ssp_pkg::SSP_E2DR: tap_next = tms_in ? ssp_pkg::SSP_UDR  : ssp_pkg::SSP_SDR;
            ssp_pkg::SSP_UDR:  tap_next = tms_in ? ssp_pkg::SSP_SDRS : ssp_pkg::SSP_RTI;
            ssp_pkg::SSP_SIRS: tap_next = tms_in ? ssp_pkg::SSP_TLR  : ssp_pkg::SSP_CIR;
            ssp_pkg::SSP_CIR:  tap_next = tms_in ? ssp_pkg::SSP_E1IR : ssp_pkg::SSP_SIR;
            ssp_pkg::SSP_SIR:  tap_next = tms_in ? ssp_pkg::SSP_E1IR : ssp_pkg::SSP_SIR;
            ssp_pkg::SSP_E1IR: tap_next = tms_in ? ssp_pkg::SSP_UIR  : ssp_pkg::SSP_PIR;
            ssp_pkg::SSP_PIR:  tap_next = tms_in ? ssp_pkg::SSP_E2IR : ssp_pkg::SSP_PIR;
            ssp_pkg::SSP_E2IR: tap_next = tms_in ? ssp_pkg::SSP_UIR  : ssp_pkg::SSP_SIR;
            ssp_pkg::SSP_UIR:  tap_next = tms_in ? ssp_pkg::SSP_SDRS : ssp_pkg::SSP_RTI;
            default:           tap_next = ssp_pkg::SSP_TLR;
        endcase
    end

    always_ff @(posedge tck_in or negedge nrst_in) begin
        if (!nrst_in) tap_reg <= ssp_pkg::SSP_TLR;
        else          tap_reg <= tap_next;
    end

    // pins owned by scan from leaving reset until it is reached again
    always_ff @(posedge tck_in or negedge nrst_in) begin
        if (!nrst_in)                          scan_own_reg <= 1'b0;
        else if (tap_next == ssp_pkg::SSP_TLR) scan_own_reg <= 1'b0;
        else                                   scan_own_reg <= 1'b1;
    end

    // instruction register
    always_ff @(posedge tck_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ir_sh_reg <= `SSP_IR_CAPTURE;
            ir_reg    <= `SSP_IR_RESET;
        end else begin
            case (tap_reg)
                ssp_pkg::SSP_TLR: ir_reg    <= `SSP_IR_RESET;
                ssp_pkg::SSP_CIR: ir_sh_reg <= `SSP_IR_CAPTURE;
                ssp_pkg::SSP_SIR: ir_sh_reg <= {tdi_in, ir_sh_reg[`SSP_IR_W-1:1]};
                ssp_pkg::SSP_UIR: ir_reg    <= ir_sh_reg;
                default:          ir_reg    <= ir_reg;
            endcase
        end
    end

    // data registers: bypass, probe select/program shift
    always_ff @(posedge tck_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dr_reg  <= '0;
            byp_reg <= 1'b0;
        end else if (tap_reg == ssp_pkg::SSP_CDR) begin
            dr_reg  <= {probe_reg.enable, probe_reg.sel_second, probe_reg.sel_first};
            byp_reg <= 1'b0;
        end else if (tap_reg == ssp_pkg::SSP_SDR) begin
            dr_reg  <= {tdi_in, dr_reg[2*SW:1]};
            byp_reg <= tdi_in;
        end
    end

    // probe selection and programming updates run on the test clock
    always_ff @(posedge tck_in or negedge nrst_in) begin
        if (!nrst_in) begin
            probe_reg     <= '0;
            probe_tgl_reg <= 1'b0;
            prog_reg      <= '0;
            prog_stb_reg  <= 1'b0;
        end else begin
            prog_stb_reg <= 1'b0;
            if (tap_reg == ssp_pkg::SSP_UDR && ir_reg == `SSP_IR_PROBE) begin
                probe_reg     <= dr_reg;
                probe_tgl_reg <= ~probe_tgl_reg;
            end
            if (tap_reg == ssp_pkg::SSP_UDR && ir_reg == `SSP_IR_PROG) begin
                prog_reg     <= dr_reg[`SSP_PROG_W-1:0];
                prog_stb_reg <= 1'b1;
            end
        end
    end

    // lock is one-way: only reset of the device model clears it
    always_ff @(posedge tck_in or negedge nrst_in) begin
        if (!nrst_in) lock_reg <= 1'b0;
        else if (tap_reg == ssp_pkg::SSP_UDR && ir_reg == `SSP_IR_LOCK) lock_reg <= 1'b1;
    end

    // data-out changes on falling test clock
    always_ff @(negedge tck_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tdo_reg    <= 1'b0;
            tdo_en_reg <= 1'b0;
        end else begin
            tdo_en_reg <= (tap_reg == ssp_pkg::SSP_SDR) || (tap_reg == ssp_pkg::SSP_SIR);
            if (tap_reg == ssp_pkg::SSP_SIR)
                tdo_reg <= ir_sh_reg[0];
            else if (ir_reg == `SSP_IR_BYPASS)
                tdo_reg <= byp_reg;
            else
                tdo_reg <= dr_reg[0];
        end
    end

    // tms high count, for checking reset arrives in five clocks
    always_ff @(posedge tck_in or negedge nrst_in) begin
        if (!nrst_in)     tms_hi_cnt <= '0;
        else if (!tms_in) tms_hi_cnt <= '0;
        else if (tms_hi_cnt != 3'h7) tms_hi_cnt <= tms_hi_cnt + 3'h1;
    end

    assign tdo_out         = tdo_reg;
    assign tdo_oe_out      = tdo_en_reg && (scan_own_reg || dedicated_mode_in);
    assign prog_word_out   = prog_reg;
    assign prog_strobe_out = prog_stb_reg;

    // crossings into mclk: single-bit levels and the probe update toggle;
    // the mode strap is a pin, so it passes the synchroniser as well
    logic                  own_sync;
    logic                  lock_sync;
    logic                  tgl_sync;
    logic                  ded_sync;
    ssp_sync2 #(.W(4)) u_sync (
        .clk_in  (mclk_in),
        .nrst_in (nrst_in),
        .d_in    ({scan_own_reg, lock_reg, probe_tgl_reg, dedicated_mode_in}),
        .q_out   ({own_sync, lock_sync, tgl_sync, ded_sync})
    );

    // probe setting taken whole once its toggle has crossed, so a select is never torn;
    // limitation: updates must lie over three mclk apart, which a full data scan
    // does unless the test clock runs more than six times faster than mclk
    logic                  tgl_seen_reg;
    ssp_pkg::ssp_probe_s   probe_m_reg;
    ssp_pkg::ssp_probe_s   probe_m;
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tgl_seen_reg <= 1'b0;
            probe_m_reg  <= '0;
        end else begin
            tgl_seen_reg <= tgl_sync;
            if (tgl_sync != tgl_seen_reg) probe_m_reg <= probe_reg;
        end
    end
    assign probe_m = probe_m_reg;

    logic       scan_mode;
    logic [1:0] probe_sel_bit;
    logic [1:0] probe_drive;
    ssp_pkg::ssp_pin_s [1:0] probe_pin_reg;
    // dedicated mode never shares the scan pins
    assign scan_mode     = own_sync || ded_sync;
    assign probe_sel_bit = {node_in[probe_m.sel_second[SW-1:0] % NODES],
                            node_in[probe_m.sel_first[SW-1:0] % NODES]};
    assign probe_drive   = {2{probe_m.enable && !lock_sync}};

    // both probe pins registered on mclk; fall back to user I/O when not probing
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_probe
            always_ff @(posedge mclk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    probe_pin_reg[g] <= '0;
                end else if (probe_drive[g]) begin
                    probe_pin_reg[g].dout <= probe_sel_bit[g];
                    probe_pin_reg[g].oe   <= 1'b1;
                end else begin
                    probe_pin_reg[g].dout <= probe_user_dout_in[g];
                    probe_pin_reg[g].oe   <= probe_user_oe_in[g];
                end
            end
        end
    endgenerate

    assign probe_out_first  = probe_pin_reg[0].dout;
    assign probe_out_second = probe_pin_reg[1].dout;
    assign probe_oe_out     = {probe_pin_reg[1].oe, probe_pin_reg[0].oe};

    // scan pins: in scan duty clock/data-in are inputs, data-out driven by scan
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scan_pin_dout_out <= '0;
            scan_pin_oe_out   <= '0;
        end else if (scan_mode) begin
            scan_pin_dout_out <= '0;
            scan_pin_oe_out   <= '0;
        end else begin
            scan_pin_dout_out <= user_dout_in;
            scan_pin_oe_out   <= user_oe_in;
        end
    end

    // pin levels seen by the user: synchronised, zero while scan owns them
    logic [2:0] pin_sync;
    ssp_sync2 #(.W(3)) u_pin_sync (
        .clk_in  (mclk_in),
        .nrst_in (nrst_in),
        .d_in    ({tdo_out, tdi_in, tck_in}),
        .q_out   (pin_sync)
    );
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in)       user_din_out <= '0;
        else if (scan_mode) user_din_out <= '0;
        else                user_din_out <= pin_sync;
    end
    assign scan_active_out  = scan_mode;
    assign probe_locked_out = lock_sync;

    // checks
    reset_in_five_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        tms_hi_cnt >= 3'(`SSP_RESET_TCKS) |-> tap_reg == ssp_pkg::SSP_TLR)
        else $error("logic reset not reached after five high tms clocks");
    // ownership may only drop on the very edge that enters logic reset
    own_hold_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        scan_own_reg |=> scan_own_reg || tap_reg == ssp_pkg::SSP_TLR)
        else $error("scan ownership dropped outside logic reset");
    own_release_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        tap_reg == ssp_pkg::SSP_TLR |-> !scan_own_reg)
        else $error("scan pins held in logic reset");
    own_enter_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        tap_reg == ssp_pkg::SSP_TLR && !tms_in |=> scan_own_reg)
        else $error("low tms did not claim scan pins");
    lock_sticky_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        lock_reg |=> lock_reg)
        else $error("probe lock cleared");
    lock_quiet_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        lock_sync |=> probe_pin_reg[0].dout == $past(probe_user_dout_in[0]))
        else $error("probe pin not user driven while locked");
    probe_route_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        probe_drive[0] |=> probe_out_first == $past(probe_sel_bit[0]) && probe_oe_out[0])
        else $error("first probe does not follow selected node");
    probe_second_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        probe_drive[1] |=> probe_out_second == $past(probe_sel_bit[1]))
        else $error("second probe does not follow selected node");
    // the release edge itself still runs the reset branch, hence nrst_in in front
    pin_release_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        nrst_in && !scan_mode |=> scan_pin_oe_out == $past(user_oe_in))
        else $error("user output enable not restored");
    shift_in_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        tap_reg == ssp_pkg::SSP_SDR |=> byp_reg == $past(tdi_in))
        else $error("bypass did not capture data-in");
    prog_pulse_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        prog_stb_reg |=> !prog_stb_reg)
        else $error("programming strobe longer than one test clock");
    tdo_release_a: assert property (@(posedge tck_in) disable iff (!nrst_in)
        tap_reg == ssp_pkg::SSP_TLR && !dedicated_mode_in |-> !tdo_oe_out)
        else $error("data-out driven by scan in logic reset");
    din_blank_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        scan_mode |=> user_din_out == 3'h0)
        else $error("user sees scan pin levels while scan owns them");
    cv_probe_c: cover property (@(posedge tck_in) disable iff (!nrst_in)
        tap_reg == ssp_pkg::SSP_UDR && ir_reg == `SSP_IR_PROBE);
    cv_lock_c: cover property (@(posedge tck_in) disable iff (!nrst_in) $rose(lock_reg));
    cv_release_c: cover property (@(posedge tck_in) disable iff (!nrst_in) $fell(scan_own_reg));
    cv_prog_c: cover property (@(posedge tck_in) disable iff (!nrst_in) prog_stb_reg);
endmodule

/* File: verif/ssp_ctrl_model.sv */
// partner model: external scan controller that makes the test clock and drives
// mode-select and data-in. It expects the device's data-out line with the release
// already resolved by the bench. The test clock idles low between frames.
`timescale 1ns/1ns
module ssp_ctrl_model (
    // link pins toward the device
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    input  wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one test clock: set while low, held through the rise, data-out taken before it
    task automatic pulse(input logic m, input logic d, output logic q);
        tms_out = m;
        tdi_out = d;
        #8;
        q = tdo_in;
        tck_out = 1'b1;
        #7;
        tck_out = 1'b0;
    endtask
    // mode-select sequence, lsb first; data-in toggles so no stale level lingers
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            pulse(seq[i], ~tdi_out, q);
        end
    endtask
    // mode-select held high for five clocks, then left high
    task automatic to_reset();
        walk(8'h1f, 5);
    endtask
    // whole instruction or data scan from idle and back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [15:0] din,
                        output logic [15:0] dout);
        logic q;
        dout = 16'h0000;
        if (ir) walk(8'h03, 4); else walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(8'h01, 2);
        tdi_out = ~tdi_out;
    endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the shared scan/probe pin control
// assumes the scan controller model drives the link; board pull-up on data-out
`timescale 1ns/1ns
`include "ssp_consts.svh"
module testbench;
    logic                   mclk_in;
    logic                   nrst_in;
    logic                   tck, tms, tdi, tdo, tdo_oe, tdo_line;
    logic                   dedicated;
    logic                   scan_active, probe_locked;
    logic [63:0]            node_in;
    logic [2:0]             user_dout, user_oe, user_din, pin_dout, pin_oe;
    logic [1:0]             probe_user_dout, probe_user_oe, probe_oe;
    logic                   probe_first, probe_second;
    logic [`SSP_PROG_W-1:0] prog_word, w;
    logic                   prog_strobe;
    logic [15:0]            dout;
    logic [5:0]             a, b;
    logic [7:0]             exp_q[$];
    int                     n_fail, total_checks;

    assign tdo_line = tdo_oe ? tdo : 1'b1;

    ssp_pin_ctrl #(.NODES(64)) uut (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .tdo_out(tdo), .tdo_oe_out(tdo_oe), .dedicated_mode_in(dedicated),
        .scan_active_out(scan_active), .probe_locked_out(probe_locked), .node_in(node_in),
        .user_dout_in(user_dout), .user_oe_in(user_oe), .user_din_out(user_din),
        .scan_pin_dout_out(pin_dout), .scan_pin_oe_out(pin_oe),
        .probe_user_dout_in(probe_user_dout), .probe_user_oe_in(probe_user_oe),
        .probe_out_first(probe_first), .probe_out_second(probe_second),
        .probe_oe_out(probe_oe), .prog_word_out(prog_word), .prog_strobe_out(prog_strobe)
    );
    ssp_ctrl_model ctrl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_line));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // sample between edges so clock-edge updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    task automatic drive_rand();
        @(posedge mclk_in);
        node_in <= {$urandom, $urandom};
        user_dout <= 3'($urandom);
        user_oe <= 3'($urandom);
        probe_user_dout <= 2'($urandom);
        probe_user_oe <= 2'($urandom);
    endtask
    // reset is asynchronous, yet the controller clocks during it so mode-select is left high
    task automatic reset_dut(input logic ded);
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        dedicated <= ded;
        fork
            repeat (12) @(posedge mclk_in);
            ctrl.to_reset();
        join
        @(posedge mclk_in);
        nrst_in <= 1'b1;
    endtask
    task automatic set_ir(input logic [3:0] code);
        ctrl.scan(1'b1, 4, {12'h000, code}, dout);
    endtask
    task automatic set_probe(input logic en, input logic [5:0] f, input logic [5:0] s);
        ctrl.scan(1'b0, 13, {3'h0, en, s, f}, dout);
        settle(6);
    endtask

    // programming words are noted by the driver and matched here on the strobe;
    // taken on the falling test clock, inside the pulse rather than at its edges
    always @(negedge tck) begin
        if (prog_strobe === 1'b1) begin
            if (exp_q.size() == 0) check(16'h0001, 16'h0000);
            else check({8'h00, prog_word}, {8'h00, exp_q.pop_front()});
        end
    end

    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        nrst_in = 1'b0;
        dedicated = 1'b0;
        node_in = 64'h0;
        user_dout = 3'h0;
        user_oe = 3'h0;
        probe_user_dout = 2'h0;
        probe_user_oe = 2'h0;
        n_fail = 0;
        total_checks = 0;
        void'($urandom(32'h16b9));
        drive_rand();
        reset_dut(1'b0);
        settle(4);
        check(scan_active, 1'b0);
        check(pin_oe, user_oe);
        check(pin_dout, user_dout);
        check(probe_oe, probe_user_oe);
        ctrl.walk(8'h00, 1);
        settle(4);
        check(scan_active, 1'b1);
        check(pin_oe, 3'h0);
        check(user_din, 3'h0);
        set_ir(`SSP_IR_PROBE);
        check(dout[3:0], `SSP_IR_CAPTURE);
        for (int k = 0; k < 3; k++) begin
            a = 6'($urandom);
            b = 6'($urandom);
            set_probe(1'b1, a, b);
            check(probe_first, node_in[a]);
            check(probe_second, node_in[b]);
            check(probe_oe, 2'h3);
            drive_rand();
            settle(3);
            check({probe_second, probe_first}, {node_in[b], node_in[a]});
        end
        check(scan_active, 1'b1);
        set_probe(1'b0, 6'h00, 6'h00);
        check(probe_oe, probe_user_oe);
        check({probe_second, probe_first}, probe_user_dout);
        set_ir(`SSP_IR_BYPASS);
        w = 8'($urandom);
        ctrl.scan(1'b0, 8, {8'h00, w}, dout);
        check(dout[7:0], {w[6:0], 1'b0});
        set_ir(`SSP_IR_PROG);
        for (int k = 0; k < 2; k++) begin
            w = 8'($urandom);
            exp_q.push_back(w);
            ctrl.scan(1'b0, 13, {8'h00, w}, dout);
        end
        ctrl.to_reset();
        settle(5);
        check(scan_active, 1'b0);
        check(pin_oe, user_oe);
        check(user_din[1:0], {tdi, 1'b0});
        check(16'(exp_q.size()), 16'h0000);
        ctrl.walk(8'h00, 1);
        set_ir(`SSP_IR_LOCK);
        set_probe(1'b0, 6'h00, 6'h00);
        set_ir(`SSP_IR_PROBE);
        set_probe(1'b1, 6'h01, 6'h02);
        check(probe_locked, 1'b1);
        check(probe_oe, probe_user_oe);
        check({probe_second, probe_first}, probe_user_dout);
        reset_dut(1'b1);
        settle(4);
        check(scan_active, 1'b1);
        check(pin_oe, 3'h0);
        check(probe_locked, 1'b0);
        ctrl.walk(8'h00, 1);
        ctrl.to_reset();
        settle(5);
        check(scan_active, 1'b1);
        report_and_stop();
    end
endmodule
